// File: logic/pdsr_pkg.sv
/*
 * Constants for the second-loop divider and spread register bank:
 * offsets, reset values, writable masks and field positions.
 * Assumes an 8-bit register space reached over the two-wire serial port.
 */
package pdsr_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int PDSR_NUM_REGS = 10;
    localparam logic [7:0] PDSR_OFF_INT_HIGH = 8'h10;
    localparam logic [7:0] PDSR_OFF_INT_LOW = 8'h11;
    localparam logic [7:0] PDSR_OFF_FRAC_LOW = 8'h12;
    localparam logic [7:0] PDSR_OFF_FRAC_HIGH = 8'h13;
    localparam logic [7:0] PDSR_OFF_STEP_LOW = 8'h14;
    localparam logic [7:0] PDSR_OFF_STEP_HIGH = 8'h15;
    localparam logic [7:0] PDSR_OFF_DELTA = 8'h16;
    localparam logic [7:0] PDSR_OFF_PERIOD_LOW = 8'h17;
    localparam logic [7:0] PDSR_OFF_PERIOD_CTRL = 8'h18;
    localparam logic [7:0] PDSR_OFF_PUMP = 8'h19;
    localparam logic [7:0] PDSR_OFF_FIRST = PDSR_OFF_INT_HIGH;
    localparam logic [7:0] PDSR_OFF_LAST = PDSR_OFF_PUMP;

    // ************************************************************
    // Reset values and writable bits, index 0 is offset 0x10
    // ************************************************************
    localparam logic [7:0] PDSR_RST_INT_HIGH = 8'h00;
    localparam logic [7:0] PDSR_RST_INT_LOW = 8'h3c;
    localparam logic [7:0] PDSR_RST_PERIOD_CTRL = 8'h0e;
    localparam logic [7:0] PDSR_RST_PUMP = 8'h14;
    localparam logic [7:0] PDSR_RST_ZERO = 8'h00;
    localparam logic [PDSR_NUM_REGS-1:0][7:0] PDSR_RST = {
        PDSR_RST_PUMP, PDSR_RST_PERIOD_CTRL, PDSR_RST_ZERO, PDSR_RST_ZERO, PDSR_RST_ZERO,
        PDSR_RST_ZERO, PDSR_RST_ZERO, PDSR_RST_ZERO, PDSR_RST_INT_LOW, PDSR_RST_INT_HIGH};
    localparam logic [7:0] PDSR_WMASK_INT_HIGH = 8'h07;
    localparam logic [7:0] PDSR_WMASK_FULL = 8'hff;
    localparam logic [PDSR_NUM_REGS-1:0][7:0] PDSR_WMASK = {
        {(PDSR_NUM_REGS-1){PDSR_WMASK_FULL}}, PDSR_WMASK_INT_HIGH};

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int PDSR_INT_HIGH_MSB = 2;
    localparam int PDSR_PERIOD_HIGH_MSB = 7;
    localparam int PDSR_PERIOD_HIGH_LSB = 6;
    localparam int PDSR_SPREAD_EN_BIT = 5;
    localparam int PDSR_FILTER_MSB = 4;
    localparam int PDSR_PUMP_MSB = 7;
    localparam int PDSR_PUMP_LSB = 1;
    localparam int PDSR_REF_SEL_BIT = 0;

    // ************************************************************
    // Serial port
    // ************************************************************
    localparam logic [3:0] PDSR_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] PDSR_LAST_READ_BIT = 4'h7;

endpackage : pdsr_pkg

// File: logic/pdsr_byte_reg.sv
/*
 * One 8-bit configuration register with a per-bit writable mask.
 * Assumes a write strobe that is one sys_clk cycle long.
 */
`timescale 1ns/1ps
module pdsr_byte_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITE_MASK = 8'hff
) (
    input wire logic sys_clk,       // Register clock
    input wire logic rst,           // Asynchronous reset, high
    input wire logic wr_en,         // One-cycle write strobe
    input wire logic [7:0] wr_data, // Byte to store
    output logic [7:0] value_q      // Stored byte
);
    // Bits outside the mask stay at zero and read back as zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            value_q <= RESET_VALUE;
        end else if (wr_en) begin
            value_q <= wr_data & WRITE_MASK;
        end
    end
endmodule : pdsr_byte_reg

// File: logic/pdsr_bank.sv
/*
 * Second-loop divider, spread and loop-filter register bank with its
 * two-wire serial slave port. Assumes open-drain pins resolved outside.
 */
`timescale 1ns/1ps
module pdsr_bank
    import pdsr_pkg::*;
#(
    parameter logic [6:0] DEVICE_ADDR = 7'h2a // Arbitrary value
) (
    input wire logic sys_clk,                            // 50 MHz register clock
    input wire logic rst,                                // Asynchronous reset, high
    input wire logic scl_in,                             // Serial clock pin
    input wire logic sda_in,                             // Serial data pin level
    output logic sda_out,                                // Serial data drive level
    output logic sda_oe,                                 // Pulls data low when high
    output logic [7:0] loop_b_fb_integer_low,            // Integer divider 7:0
    output logic [2:0] loop_b_fb_integer_high,           // Integer divider 10:8
    output logic [10:0] loop_b_fb_integer,               // Full integer divider
    output logic [15:0] loop_b_fb_fraction,              // Fractional divider
    output logic [15:0] loop_b_spread_step,              // Spread step size
    output logic [7:0] loop_b_spread_step_delta,         // Spread step delta
    output logic [9:0] loop_b_spread_period,             // Spread period
    output logic loop_b_spread_enable,                   // Spread on
    output logic loop_b_filter_res_largest,              // Add largest resistor
    output logic loop_b_filter_res_large,                // Add large resistor
    output logic loop_b_filter_res_medium,               // Add medium resistor
    output logic loop_b_filter_res_small,                // Add small resistor
    output logic loop_b_filter_res_only_min,             // Minimum resistor only
    output logic loop_b_pump_times_sixteen,              // Pump x16
    output logic loop_b_pump_times_eight,                // Pump x8
    output logic loop_b_pump_times_four,                 // Pump x4
    output logic loop_b_pump_times_two,                  // Pump x2
    output logic loop_b_pump_times_one,                  // Pump x1
    output logic loop_b_pump_div_twentyfour,             // Pump /24
    output logic loop_b_pump_div_three,                  // Pump /3
    output logic loop_b_ref_current_select               // Doubled reference current
);
    import pdsr_pkg::*;

    typedef enum {
        PDSR_IDLE, PDSR_DEVADDR, PDSR_REGPTR, PDSR_WDATA, PDSR_ACK, PDSR_RDATA, PDSR_RACK
    } pdsr_state_t;

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic logic in_bank(input logic [7:0] addr);
        in_bank = (addr >= PDSR_OFF_FIRST) && (addr <= PDSR_OFF_LAST);
    endfunction : in_bank

    function automatic logic [3:0] reg_index(input logic [7:0] addr);
        logic [7:0] diff;
        diff = addr - PDSR_OFF_FIRST;
        reg_index = diff[3:0];
    endfunction : reg_index

    // ************************************************************
    // Pin synchronisers and bus conditions
    // ************************************************************
    logic scl_s1_q, scl_s2_q, scl_s3_q;
    logic sda_s1_q, sda_s2_q, sda_s3_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end else begin
            scl_s1_q <= scl_in;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= sda_in;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise = scl_s2_q & ~scl_s3_q;
    assign scl_fall = ~scl_s2_q & scl_s3_q;
    assign start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    assign stop_det = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

    // ************************************************************
    // Register storage
    // ************************************************************
    logic [7:0] bank_q [PDSR_NUM_REGS];
    pdsr_state_t st_q, after_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q, ptr_q;
    logic nack_q, sda_oe_q, sda_out_q;
    logic wr_stb;
    logic [7:0] rd_val;

    // Write lands on the falling clock that ends the eighth data bit
    assign wr_stb = (st_q == PDSR_WDATA) && scl_fall && (cnt_q == PDSR_BITS_PER_BYTE) && !start_det && !stop_det;

    genvar gi;
    generate
        for (gi = 0; gi < PDSR_NUM_REGS; gi++) begin : g_reg
            pdsr_byte_reg #(
                .RESET_VALUE(PDSR_RST[gi]),
                .WRITE_MASK(PDSR_WMASK[gi])
            ) u_reg (
                .sys_clk(sys_clk),
                .rst(rst),
                .wr_en(wr_stb && in_bank(ptr_q) && (reg_index(ptr_q) == 4'(gi))),
                .wr_data(sh_q),
                .value_q(bank_q[gi])
            );
        end
    endgenerate

    // Unmapped offsets read zero and ignore writes
    assign rd_val = in_bank(ptr_q) ? bank_q[reg_index(ptr_q)] : 8'h00;

    // ************************************************************
    // Serial slave sequencer
    // ************************************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q <= PDSR_IDLE;
            after_q <= PDSR_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            nack_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (start_det) begin
            st_q <= PDSR_DEVADDR;
            cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end else if (stop_det) begin
            st_q <= PDSR_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            unique case (st_q)
                PDSR_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                PDSR_DEVADDR, PDSR_REGPTR, PDSR_WDATA: begin
                    if (scl_rise && cnt_q != PDSR_BITS_PER_BYTE) begin
                        sh_q <= {sh_q[6:0], sda_s2_q};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == PDSR_BITS_PER_BYTE) begin
                        cnt_q <= 4'h0;
                        st_q <= PDSR_ACK;
                        sda_oe_q <= 1'b1;
                        if (st_q == PDSR_DEVADDR) begin
                            // A foreign address leaves the bus alone until the next start
                            if (sh_q[7:1] != DEVICE_ADDR) begin
                                st_q <= PDSR_IDLE;
                                sda_oe_q <= 1'b0;
                            end
                            after_q <= sh_q[0] ? PDSR_RDATA : PDSR_REGPTR;
                        end else if (st_q == PDSR_REGPTR) begin
                            ptr_q <= sh_q;
                            after_q <= PDSR_WDATA;
                        end else begin
                            ptr_q <= ptr_q + 8'h01;
                            after_q <= PDSR_WDATA;
                        end
                    end
                end
                PDSR_ACK: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        st_q <= after_q;
                        if (after_q == PDSR_RDATA) begin
                            sh_q <= rd_val;
                            sda_oe_q <= ~rd_val[7];
                        end else begin
                            sda_oe_q <= 1'b0;
                        end
                    end
                end
                PDSR_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_q == PDSR_LAST_READ_BIT) begin
                            sda_oe_q <= 1'b0;
                            st_q <= PDSR_RACK;
                            ptr_q <= ptr_q + 8'h01;
                        end else begin
                            sh_q <= {sh_q[6:0], 1'b0};
                            sda_oe_q <= ~sh_q[6];
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                end
                PDSR_RACK: begin
                    if (scl_rise) begin
                        nack_q <= sda_s2_q;
                    end else if (scl_fall) begin
                        // Master's not-acknowledge ends the read burst
                        if (nack_q) begin
                            st_q <= PDSR_IDLE;
                        end else begin
                            st_q <= PDSR_RDATA;
                            cnt_q <= 4'h0;
                            sh_q <= rd_val;
                            sda_oe_q <= ~rd_val[7];
                        end
                    end
                end
            endcase
        end
    end

    // Open drain: the pin is only ever pulled low
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sda_out_q <= 1'b0;
        end else begin
            sda_out_q <= 1'b0;
        end
    end

    assign sda_out = sda_out_q;
    assign sda_oe = sda_oe_q;

    // ************************************************************
    // Field outputs, all straight from the register flops
    // ************************************************************
    assign loop_b_fb_integer_low = bank_q[1];
    assign loop_b_fb_integer_high = bank_q[0][PDSR_INT_HIGH_MSB:0];
    assign loop_b_fb_integer = {bank_q[0][PDSR_INT_HIGH_MSB:0], bank_q[1]};
    assign loop_b_fb_fraction = {bank_q[3], bank_q[2]};
    assign loop_b_spread_step = {bank_q[5], bank_q[4]};
    assign loop_b_spread_step_delta = bank_q[6];
    assign loop_b_spread_period = {bank_q[8][PDSR_PERIOD_HIGH_MSB:PDSR_PERIOD_HIGH_LSB], bank_q[7]};
    assign loop_b_spread_enable = bank_q[8][PDSR_SPREAD_EN_BIT];
    assign {loop_b_filter_res_largest, loop_b_filter_res_large, loop_b_filter_res_medium,
            loop_b_filter_res_small, loop_b_filter_res_only_min} = bank_q[8][PDSR_FILTER_MSB:0];
    assign {loop_b_pump_times_sixteen, loop_b_pump_times_eight, loop_b_pump_times_four,
            loop_b_pump_times_two, loop_b_pump_times_one, loop_b_pump_div_twentyfour,
            loop_b_pump_div_three} = bank_q[9][PDSR_PUMP_MSB:PDSR_PUMP_LSB];
    assign loop_b_ref_current_select = bank_q[9][PDSR_REF_SEL_BIT];

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_write_to(logic [7:0] off);
        wr_stb && ptr_q == off;
    endsequence

    chk_int_low_reset: assert property ($fell(rst) |-> loop_b_fb_integer_low == PDSR_RST_INT_LOW)
        else $error("integer low byte reset wrong");
    chk_int_high_mask: assert property (s_write_to(PDSR_OFF_INT_HIGH) |=>
        bank_q[0] == {5'h00, $past(sh_q[2:0])} && loop_b_fb_integer[10:8] == $past(sh_q[2:0]))
        else $error("integer high bits wrong");
    chk_frac_high_write: assert property (s_write_to(PDSR_OFF_FRAC_HIGH) |=>
        loop_b_fb_fraction[15:8] == $past(sh_q) && $stable(loop_b_fb_fraction[7:0]))
        else $error("fraction high byte wrong");
    chk_step_low_write: assert property (s_write_to(PDSR_OFF_STEP_LOW) |=>
        loop_b_spread_step[7:0] == $past(sh_q) && $stable(loop_b_spread_step[15:8]))
        else $error("step low byte wrong");
    chk_delta_write: assert property (s_write_to(PDSR_OFF_DELTA) |=> loop_b_spread_step_delta == $past(sh_q))
        else $error("step delta wrong");
    chk_period_high_write: assert property (s_write_to(PDSR_OFF_PERIOD_CTRL) |=>
        loop_b_spread_period[9:8] == $past(sh_q[7:6]) && loop_b_spread_enable == $past(sh_q[5]))
        else $error("period high or spread enable wrong");
    chk_filter_reset: assert property ($fell(rst) |->
        {loop_b_filter_res_largest, loop_b_filter_res_large, loop_b_filter_res_medium,
         loop_b_filter_res_small, loop_b_filter_res_only_min} == 5'b01110 && !loop_b_spread_enable)
        else $error("filter selects reset wrong");
    chk_filter_write: assert property (s_write_to(PDSR_OFF_PERIOD_CTRL) |=>
        loop_b_filter_res_only_min == $past(sh_q[0]) && loop_b_filter_res_largest == $past(sh_q[4]))
        else $error("filter selects not writable");
    chk_pump_reset: assert property ($fell(rst) |-> loop_b_pump_times_two && loop_b_pump_div_twentyfour &&
        !loop_b_pump_times_one && !loop_b_ref_current_select)
        else $error("pump reset wrong");
    chk_pump_write: assert property (s_write_to(PDSR_OFF_PUMP) |=>
        loop_b_pump_times_sixteen == $past(sh_q[7]) && loop_b_ref_current_select == $past(sh_q[0]))
        else $error("pump register write wrong");
    chk_read_value: assert property (((st_q == PDSR_ACK && after_q == PDSR_RDATA) || (st_q == PDSR_RACK && !nack_q))
        && scl_fall && !start_det && !stop_det && ptr_q == PDSR_OFF_INT_LOW |=> sh_q == loop_b_fb_integer_low)
        else $error("read byte differs from stored value");
endmodule : pdsr_bank

// File: sim/test_pdsr_bank.sv
/*
 * Self-checking bench for the second-loop divider and spread register bank.
 * Assumes the bench is the only serial master; it resolves the open-drain data wire itself.
 */
`timescale 1ns/1ps
module test_pdsr_bank;
    import pdsr_pkg::*;

    localparam logic [6:0] dev_addr = 7'h2a; // Arbitrary value
    logic sys_clk, rst, scl_m, sda_m, sda_in, sda_out, sda_oe;
    logic [7:0] int_low, delta, rbyte;
    logic [2:0] int_high;
    logic [10:0] int_all;
    logic [15:0] frac, step;
    logic [9:0] period;
    logic [4:0] filt;
    logic [6:0] pump;
    logic ss_en, ref_sel, ack_s;
    logic [7:0] img [10];
    logic [7:0] buf8 [10];
    int fails = 0;
    int n_tests = 0;

    // Wired-AND of the bench's release level and the device's pull-down
    assign sda_in = sda_m & ~(sda_oe & ~sda_out);

    pdsr_bank #(.DEVICE_ADDR(dev_addr)) DUT (
        .sys_clk(sys_clk), .rst(rst), .scl_in(scl_m), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .loop_b_fb_integer_low(int_low), .loop_b_fb_integer_high(int_high), .loop_b_fb_integer(int_all),
        .loop_b_fb_fraction(frac), .loop_b_spread_step(step), .loop_b_spread_step_delta(delta),
        .loop_b_spread_period(period), .loop_b_spread_enable(ss_en),
        .loop_b_filter_res_largest(filt[4]), .loop_b_filter_res_large(filt[3]),
        .loop_b_filter_res_medium(filt[2]), .loop_b_filter_res_small(filt[1]),
        .loop_b_filter_res_only_min(filt[0]), .loop_b_pump_times_sixteen(pump[6]),
        .loop_b_pump_times_eight(pump[5]), .loop_b_pump_times_four(pump[4]), .loop_b_pump_times_two(pump[3]),
        .loop_b_pump_times_one(pump[2]), .loop_b_pump_div_twentyfour(pump[1]),
        .loop_b_pump_div_three(pump[0]), .loop_b_ref_current_select(ref_sel)
    );

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // ************************************************************
    // Serial master tasks
    // ************************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    // Eight clocks per phase keeps well above the four-clock minimum
    task automatic pins(input logic c, input logic d);
        scl_m = c;
        sda_m = d;
        tick(8);
    endtask : pins

    task automatic start_c();
        pins(scl_m, 1'b1);
        pins(1'b1, 1'b1);
        pins(1'b1, 1'b0);
        pins(1'b0, 1'b0);
    endtask : start_c

    task automatic stop_c();
        pins(1'b0, 1'b0);
        pins(1'b1, 1'b0);
        pins(1'b1, 1'b1);
    endtask : stop_c

    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) begin
            pins(1'b0, d[i]);
            pins(1'b1, d[i]);
            r[i] = sda_in;
            pins(1'b0, d[i]);
        end
        pins(1'b0, last);
        pins(1'b1, last);
        a = ~sda_in;
        pins(1'b0, last);
    endtask : xfer

    task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_val

    // Writes n bytes from buf8 and keeps the bench's image of the bank
    task automatic wr(input logic [7:0] off, input int n);
        logic [7:0] r;
        logic a;
        start_c();
        xfer({dev_addr, 1'b0}, 1'b1, r, a);
        chk_val("write address ack", 16'(1'b1), 16'(a));
        xfer(off, 1'b1, r, a);
        for (int i = 0; i < n; i++) begin
            xfer(buf8[i], 1'b1, r, a);
            if (off + i <= 8'h19)
                img[off + i - 16] = buf8[i] & ((off + i == 8'h10) ? 8'h07 : 8'hff);
        end
        stop_c();
    endtask : wr

    // Reads n bytes and compares each with the image; unmapped places read zero
    task automatic rd(input logic [7:0] off, input int n);
        logic [7:0] r;
        logic [7:0] exp;
        logic a;
        start_c();
        xfer({dev_addr, 1'b0}, 1'b1, r, a);
        xfer(off, 1'b1, r, a);
        start_c();
        xfer({dev_addr, 1'b1}, 1'b1, r, a);
        chk_val("read address ack", 16'(1'b1), 16'(a));
        for (int i = 0; i < n; i++) begin
            xfer(8'hff, i == n - 1, r, a);
            exp = (off + i <= 8'h19) ? img[off + i - 16] : 8'h00;
            chk_val($sformatf("register %h", off + i), 16'(exp), 16'(r));
        end
        stop_c();
    endtask : rd

    // ************************************************************
    // Field outputs against the image
    // ************************************************************
    task automatic chk_fields();
        chk_val("integer low", 16'(img[1]), 16'(int_low));
        chk_val("integer high", 16'(img[0][2:0]), 16'(int_high));
        chk_val("integer", 16'({img[0][2:0], img[1]}), 16'(int_all));
        chk_val("fraction", {img[3], img[2]}, frac);
        chk_val("step", {img[5], img[4]}, step);
        chk_val("delta", 16'(img[6]), 16'(delta));
        chk_val("period", 16'({img[8][7:6], img[7]}), 16'(period));
        chk_val("spread enable", 16'(img[8][5]), 16'(ss_en));
        chk_val("filter", 16'(img[8][4:0]), 16'(filt));
        chk_val("pump", 16'(img[9][7:1]), 16'(pump));
        chk_val("ref current", 16'(img[9][0]), 16'(ref_sel));
    endtask : chk_fields

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (80000) @(posedge sys_clk);
        fails++;
        $display("[FAIL] watchdog expected done seen hang");
        finish_test();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        rst = 1'b1;
        scl_m = 1'b1;
        sda_m = 1'b1;
        img = '{8'h00, 8'h3c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0e, 8'h14};
        tick(12);
        rst = 1'b0;
        tick(8);
        chk_fields();
        rd(8'h10, 10);
        $display("test reset_defaults done, mismatches %0d", fails);
        // A pattern and its inverse toggle every bit of every field
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 10; i++)
                buf8[i] = 8'(8'ha5 + 8'h11 * i) ^ {8{k[0]}};
            wr(8'h10, 10);
            chk_fields();
            rd(8'h10, 10);
        end
        $display("test burst_patterns done, mismatches %0d", fails);
        buf8[0] = 8'h55;
        wr(8'h16, 1);
        buf8[0] = 8'h77;
        wr(8'h1a, 1);
        chk_fields();
        rd(8'h18, 3);
        $display("test single_and_unmapped done, mismatches %0d", fails);
        // Another device's frame must leave the bank alone
        start_c();
        xfer({dev_addr ^ 7'h01, 1'b0}, 1'b1, rbyte, ack_s);
        chk_val("foreign address ack", 16'(1'b0), 16'(ack_s));
        xfer(8'h16, 1'b1, rbyte, ack_s);
        xfer(8'h00, 1'b1, rbyte, ack_s);
        stop_c();
        chk_fields();
        $display("test foreign_address done, mismatches %0d", fails);
        // Reset lands in the middle of a write frame
        start_c();
        xfer({dev_addr, 1'b0}, 1'b1, rbyte, ack_s);
        xfer(8'h16, 1'b1, rbyte, ack_s);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        stop_c();
        img = '{8'h00, 8'h3c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0e, 8'h14};
        chk_fields();
        rd(8'h10, 10);
        $display("test reset_mid_frame done, mismatches %0d", fails);
        finish_test();
    end

endmodule : test_pdsr_bank
